// ### src/tcs_byte_counter.v
// One 8-bit auto-reload counter half with wrap pulse
`timescale 1ns/1ps
`include "tcs_defines.vh"
module tcs_byte_counter (
   input  wire       clk_i,    // System clock
   input  wire       rst_i,    // Synchronous reset
   input  wire       inc_i,    // Increment this cycle
   input  wire       load_i,   // Force reload
   input  wire [7:0] reload_i, // Reload byte
   input  wire       wr_i,     // Software write of count
   input  wire [7:0] wdata_i,  // Written count
   output reg  [7:0] cnt_o,    // Current count
   output wire       wrap_o    // Wrap from all ones this cycle
);
   assign wrap_o = inc_i && (cnt_o == `TCS_BYTE_MAX);

   // Software write wins, then reload, then count
   always @(posedge clk_i) begin
      if (rst_i)
         cnt_o <= `TCS_BYTE_ZERO;
      else if (wr_i)
         cnt_o <= wdata_i;
      else if (load_i)
         cnt_o <= reload_i;
      else if (inc_i)
         cnt_o <= cnt_o + 8'h01;
   end
endmodule // tcs_byte_counter

// ### src/tcs_defines.vh
// Constants for the timer clock select and timer C block
`ifndef TCS_DEFINES_VH
`define TCS_DEFINES_VH
// Clock select register fields
`define TCS_CKS_RESET     8'h00
`define TCS_CKS_C_HIGH    7
`define TCS_CKS_C_LOW     6
`define TCS_CKS_B_HIGH    5
`define TCS_CKS_B_LOW     4
`define TCS_CKS_ONE       3
`define TCS_CKS_ZERO      2
`define TCS_CKS_PRE_HI    1
`define TCS_CKS_PRE_LO    0
// Prescale codes and divide ratios
`define TCS_PRE_DIV12     2'h0
`define TCS_PRE_DIV4      2'h1
`define TCS_PRE_DIV48     2'h2
`define TCS_DIV_12        6'h0c
`define TCS_DIV_4         6'h04
`define TCS_DIV_48        6'h30
`define TCS_DIV_RSVD      6'h0c
`define TCS_DIV_EXT       6'h08
`define TCS_DIV_W         6
// Timer C control register fields
`define TCS_CTL_OVF_HIGH  7
`define TCS_CTL_OVF_LOW   6
`define TCS_CTL_LOW_IRQ   5
`define TCS_CTL_RUN       2
`define TCS_CTL_SPLIT     3
`define TCS_CTL_EXT_CHO   0
`define TCS_CTL_RESET     8'h00
`define TCS_IRQ_EN_BIT    7
`define TCS_BYTE_MAX      8'hff
`define TCS_BYTE_ZERO     8'h00
`define TCS_ONE_CNT       6'h01
`define TCS_ZERO_CNT      6'h00
`endif

// ### src/tcs_divider.v
// Tick generator dividing its advance pulses by a selectable ratio
`timescale 1ns/1ps
`include "tcs_defines.vh"
module tcs_divider (
   input  wire                   clk_i,   // System clock
   input  wire                   rst_i,   // Synchronous reset
   input  wire                   adv_i,   // Count enable from source
   input  wire [`TCS_DIV_W-1:0]  ratio_i, // Divide ratio
   output reg                    tick_o   // One pulse per ratio advances
);
   reg [`TCS_DIV_W-1:0] cnt;

   // Counts advances; ratio change takes effect at once, in the next compare
   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt    <= `TCS_ZERO_CNT;
         tick_o <= 1'b0;
      end else begin
         tick_o <= 1'b0;
         if (adv_i) begin
            if (cnt >= ratio_i - `TCS_ONE_CNT) begin
               cnt    <= `TCS_ZERO_CNT;
               tick_o <= 1'b1;
            end else begin
               cnt <= cnt + `TCS_ONE_CNT;
            end
         end
      end
   end
endmodule // tcs_divider

// ### src/tcs_timer.v
// Timer clock select register, shared prescaler and timer C
// Contract
// - Timer C high clock select acts only in split mode, 1 picking the system clock.
// - Timer C low clock select picks its external choice at 0 and system clock at 1.
// - Timer B low select, and high select in split mode only, pick external choice at 0, system clock at 1.
// - Timer one select picks prescaled clock at 0, system clock at 1, ignored as counter.
// - Timer zero select picks prescaled clock at 0, system clock at 1, ignored as counter.
// - Prescale code 00 divides by 12, 01 by 4 and 10 by 48.
// - Timer C is two bytes, split bit 3 chooses 16-bit or dual 8-bit reload.
// - Timer C runs on system clock, system clock/12 or synchronized external/8.
// - In 16-bit mode a wrap from all ones reloads and sets the high overflow flag.
// - With timer C interrupt enabled every high overflow requests an interrupt.
// - With the low interrupt bit also set, low byte wraps request an interrupt.
// - With bus low timeout on, clock line high forces reload and low lets it count.
`timescale 1ns/1ps
`include "tcs_defines.vh"
module tcs_timer (
   input  wire       clk_i,                // System clock, 20 MHz
   input  wire       rst_i,                // Synchronous reset, active high
   input  wire       cks_wr_i,             // Write strobe, clock select register
   input  wire       ctl_wr_i,             // Write strobe, timer C control
   input  wire       cnt_low_wr_i,         // Write strobe, timer C count low
   input  wire       cnt_high_wr_i,        // Write strobe, timer C count high
   input  wire       rld_low_wr_i,         // Write strobe, timer C reload low
   input  wire       rld_high_wr_i,        // Write strobe, timer C reload high
   input  wire [7:0] wdata_i,              // Write data
   input  wire       ext_irq_enable_i,     // Timer C interrupt enable level
   input  wire       tmr_zero_counter_mode_i, // Timer zero counts events
   input  wire       tmr_one_counter_mode_i,  // Timer one counts events
   input  wire       tmr_b_ext_clk_choice_i,  // Timer B external choice, 0 system_clock/12
   input  wire       tmr_b_split_mode_i,      // Timer B split mode
   input  wire       ext_osc_i,            // External oscillator, asynchronous
   input  wire       bus_low_timeout_en_i, // Serial bus low timeout enable
   input  wire       bus_clk_line_i,       // Serial clock line level, asynchronous
   output reg  [7:0] timer_clock_select_o, // Clock select register readback
   output reg  [7:0] tmr_c_control_o,      // Timer C control readback
   output reg  [7:0] tmr_c_count_low_o,    // Timer C count low
   output reg  [7:0] tmr_c_count_high_o,   // Timer C count high
   output reg  [7:0] tmr_c_reload_low_o,   // Timer C reload low
   output reg  [7:0] tmr_c_reload_high_o,  // Timer C reload high
   output reg        tmr_zero_tick_o,      // Timer zero timebase tick
   output reg        tmr_one_tick_o,       // Timer one timebase tick
   output reg        tmr_b_low_tick_o,     // Timer B low timebase tick
   output reg        tmr_b_high_tick_o,    // Timer B high timebase tick
   output reg        tmr_c_irq_o           // Timer C interrupt request level
);
   reg  [`TCS_DIV_W-1:0] pre_ratio;
   reg                   ext_s1;
   reg                   ext_s2;
   reg                   ext_s3;
   reg                   scl_s1;
   reg                   scl_s2;
   wire                  pre_tick;
   wire                  sys12_tick;
   wire                  ext8_tick;
   wire                  ext_edge;
   wire [7:0]            low_cnt;
   wire [7:0]            high_cnt;
   wire                  low_wrap;
   wire                  high_wrap;
   reg                   low_inc;
   reg                   high_inc;
   reg                   low_load;
   reg                   high_load;
   reg                   c_alt_tick;
   wire                  split;
   wire                  run;
   wire                  force_rld;
   wire [7:0]            cks;
   wire [7:0]            ctl;

   // Behaviour notes for whoever picks this block up next:
   // The clock select register has no read side effects; every bit is plain storage.
   // Its prescale field drives one shared divider for timers zero and one.
   // A new prescale code is honoured at once, not at the divider's next wrap,
   // so the first tick after a change may come early but never late.
   // Timers zero and one get a one-cycle tick per prescaled period, or a steady
   // high level when the system clock is chosen; event mode forces the tick low.
   // Timer B only gets its timebase here; its counter lives elsewhere, and the
   // high tick follows the low select unless split mode is reported.
   // Timer C keeps its whole counter here, as two byte halves.
   // The external oscillator must stay below half the system clock, or edges are lost;
   // it passes two flops, then an edge detector, then a divide-by-eight.
   // The clock line from the serial interface passes two flops as well, and
   // resets high so that an enabled timeout starts out holding the reload value.
   // Priority inside each half: software count write, then reload, then count.
   // In 16-bit mode the low half carries into the high half, and both reload
   // together only when the whole count wraps from all ones or while the timeout forces reload.
   // In split mode each half runs from its own select and reloads on its own wrap.
   // Overflow flags are set by hardware and cleared by software writes to the
   // control register; a set in the same cycle as a clear wins, so no overflow
   // is ever lost, at the cost of a stray flag after a late clear.
   // The interrupt request is a registered level, one cycle behind the flags,
   // and it stays high until software clears the flag that raised it.
   // The count readback is registered too, one cycle behind the counters, which
   // keeps every top-level output on a flop at the cost of a cycle of latency.
   // The reserved prescale code falls back to divide-by-twelve, the reset ratio.
   // No long counts are kept here: the timeout period is entirely the reload
   // value that software chooses, and the overflow handler does the bus reset.

   assign cks   = timer_clock_select_o;
   assign ctl   = tmr_c_control_o;
   assign split = ctl[`TCS_CTL_SPLIT];
   assign run   = ctl[`TCS_CTL_RUN];

   // Clock select register, all bits writable
   always @(posedge clk_i) begin
      if (rst_i)
         timer_clock_select_o <= `TCS_CKS_RESET;
      else if (cks_wr_i)
         timer_clock_select_o <= wdata_i;
   end

   // Prescale ratio; reserved code falls back to a fixed divider
   always @* begin
      case (cks[`TCS_CKS_PRE_HI:`TCS_CKS_PRE_LO])
         `TCS_PRE_DIV12: pre_ratio = `TCS_DIV_12;
         `TCS_PRE_DIV4:  pre_ratio = `TCS_DIV_4;
         `TCS_PRE_DIV48: pre_ratio = `TCS_DIV_48;
         default:        pre_ratio = `TCS_DIV_RSVD;
      endcase
   end

   // Shared prescaler for timers zero and one
   tcs_divider u_pre (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .adv_i   (1'b1),
      .ratio_i (pre_ratio),
      .tick_o  (pre_tick)
   );

   // Fixed divide-by-12 of system clock for the B and C alternatives
   tcs_divider u_sys12 (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .adv_i   (1'b1),
      .ratio_i (`TCS_DIV_12),
      .tick_o  (sys12_tick)
   );

   // External oscillator and clock line, two flops before any use
   always @(posedge clk_i) begin
      if (rst_i) begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_s3 <= 1'b0;
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
      end else begin
         ext_s1 <= ext_osc_i;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
         scl_s1 <= bus_clk_line_i;
         scl_s2 <= scl_s1;
      end
   end

   // Rising edges of the synchronized oscillator; must be under half system_clock
   assign ext_edge = ext_s2 & ~ext_s3;

   tcs_divider u_ext8 (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .adv_i   (ext_edge),
      .ratio_i (`TCS_DIV_EXT),
      .tick_o  (ext8_tick)
   );

   // Timebase ticks for timers zero, one and B; event mode bypasses select
   always @(posedge clk_i) begin
      if (rst_i) begin
         tmr_zero_tick_o   <= 1'b0;
         tmr_one_tick_o    <= 1'b0;
         tmr_b_low_tick_o  <= 1'b0;
         tmr_b_high_tick_o <= 1'b0;
      end else begin
         tmr_zero_tick_o <= tmr_zero_counter_mode_i ? 1'b0 :
                            (cks[`TCS_CKS_ZERO] ? 1'b1 : pre_tick);
         tmr_one_tick_o  <= tmr_one_counter_mode_i ? 1'b0 :
                            (cks[`TCS_CKS_ONE] ? 1'b1 : pre_tick);
         tmr_b_low_tick_o <= cks[`TCS_CKS_B_LOW] ? 1'b1 :
                            (tmr_b_ext_clk_choice_i ? ext8_tick : sys12_tick);
         if (tmr_b_split_mode_i)
            tmr_b_high_tick_o <= cks[`TCS_CKS_B_HIGH] ? 1'b1 :
                            (tmr_b_ext_clk_choice_i ? ext8_tick : sys12_tick);
         else
            tmr_b_high_tick_o <= cks[`TCS_CKS_B_LOW] ? 1'b1 :
                            (tmr_b_ext_clk_choice_i ? ext8_tick : sys12_tick);
      end
   end

   // Timer C alternative source: external choice bit picks ext/8 or sys/12
   always @* begin
      c_alt_tick = ctl[`TCS_CTL_EXT_CHO] ? ext8_tick : sys12_tick;
   end

   // Clock line high holds timer C in reload while the timeout is enabled
   assign force_rld = bus_low_timeout_en_i & scl_s2;

   // Increment and reload decisions for both halves
   always @* begin
      low_inc   = 1'b0;
      high_inc  = 1'b0;
      low_load  = force_rld;
      high_load = force_rld;
      if (run && !force_rld) begin
         low_inc = cks[`TCS_CKS_C_LOW] ? 1'b1 : c_alt_tick;
         if (split) begin
            // High select only honoured here
            high_inc = cks[`TCS_CKS_C_HIGH] ? 1'b1 : c_alt_tick;
            low_load  = low_wrap;
            high_load = high_wrap;
         end else begin
            // Carry ripples from low into high
            high_inc  = low_wrap;
            low_load  = low_wrap && (high_cnt == `TCS_BYTE_MAX);
            high_load = low_load;
         end
      end
   end

   tcs_byte_counter u_low (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .inc_i    (low_inc),
      .load_i   (low_load),
      .reload_i (tmr_c_reload_low_o),
      .wr_i     (cnt_low_wr_i),
      .wdata_i  (wdata_i),
      .cnt_o    (low_cnt),
      .wrap_o   (low_wrap)
   );

   tcs_byte_counter u_high (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .inc_i    (high_inc),
      .load_i   (high_load),
      .reload_i (tmr_c_reload_high_o),
      .wr_i     (cnt_high_wr_i),
      .wdata_i  (wdata_i),
      .cnt_o    (high_cnt),
      .wrap_o   (high_wrap)
   );

   // Registered count readback, one cycle behind the counters
   always @(posedge clk_i) begin
      if (rst_i) begin
         tmr_c_count_low_o  <= `TCS_BYTE_ZERO;
         tmr_c_count_high_o <= `TCS_BYTE_ZERO;
      end else begin
         tmr_c_count_low_o  <= low_cnt;
         tmr_c_count_high_o <= high_cnt;
      end
   end

   // Reload registers
   always @(posedge clk_i) begin
      if (rst_i) begin
         tmr_c_reload_low_o  <= `TCS_BYTE_ZERO;
         tmr_c_reload_high_o <= `TCS_BYTE_ZERO;
      end else begin
         if (rld_low_wr_i)
            tmr_c_reload_low_o <= wdata_i;
         if (rld_high_wr_i)
            tmr_c_reload_high_o <= wdata_i;
      end
   end

   // Control register; overflow set beats a same-cycle software clear
   always @(posedge clk_i) begin
      if (rst_i) begin
         tmr_c_control_o <= `TCS_CTL_RESET;
      end else begin
         if (ctl_wr_i)
            tmr_c_control_o <= wdata_i;
         if (split ? high_wrap && high_inc : high_load && !force_rld)
            tmr_c_control_o[`TCS_CTL_OVF_HIGH] <= 1'b1;
         if (low_wrap)
            tmr_c_control_o[`TCS_CTL_OVF_LOW] <= 1'b1;
      end
   end

   // Interrupt level from flags; low flag counts only with its enable
   always @(posedge clk_i) begin
      if (rst_i)
         tmr_c_irq_o <= 1'b0;
      else
         tmr_c_irq_o <= ext_irq_enable_i &&
                        (ctl[`TCS_CTL_OVF_HIGH] ||
                         (ctl[`TCS_CTL_LOW_IRQ] && ctl[`TCS_CTL_OVF_LOW]));
   end
endmodule // tcs_timer

// ### verif/tcs_timer_asserts.sv
// Port-level assertions for the timer clock select block
`timescale 1ns/1ps
module tcs_timer_asserts (
   input wire logic       clk_i, rst_i, cks_wr_i, ctl_wr_i,        // Clock, reset, strobes
   input wire logic       cnt_low_wr_i, cnt_high_wr_i,             // Count strobes
   input wire logic       rld_low_wr_i, rld_high_wr_i,             // Reload strobes
   input wire logic       ext_irq_enable_i, bus_low_timeout_en_i,  // Enables
   input wire logic       tmr_zero_counter_mode_i, tmr_one_counter_mode_i, // Event modes
   input wire logic       bus_clk_line_i,                          // Serial clock line
   input wire logic [7:0] wdata_i, timer_clock_select_o, tmr_c_control_o, // Data, regs
   input wire logic [7:0] tmr_c_count_low_o, tmr_c_count_high_o,   // Count
   input wire logic [7:0] tmr_c_reload_low_o, tmr_c_reload_high_o, // Reload
   input wire logic       tmr_zero_tick_o, tmr_one_tick_o,         // Ticks
   input wire logic       tmr_b_low_tick_o, tmr_c_irq_o            // Tick, request
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Count or reload writes move the count, so the hold check waits for quiet
   wire       quiet = !(cnt_low_wr_i || cnt_high_wr_i || rld_low_wr_i || rld_high_wr_i);
   wire [15:0] cnt  = {tmr_c_count_high_o, tmr_c_count_low_o};
   wire [7:0]  ctl  = tmr_c_control_o;
   wire [7:0]  cks  = timer_clock_select_o;
   property p_cks_wr; cks_wr_i |=> cks == $past(wdata_i); endproperty
   a_cks_wr: assert property (p_cks_wr) else $error("clock select write lost");
   property p_cks_hold; !cks_wr_i |=> $stable(cks); endproperty
   a_cks_hold: assert property (p_cks_hold) else $error("clock select moved");
   property p_zero_sys; (cks[2] && !tmr_zero_counter_mode_i)[*3] |-> tmr_zero_tick_o; endproperty
   a_zero_sys: assert property (p_zero_sys) else $error("timer zero not on system_clock");
   property p_zero_evt; tmr_zero_counter_mode_i[*3] |-> !tmr_zero_tick_o; endproperty
   a_zero_evt: assert property (p_zero_evt) else $error("timer zero ticks as counter");
   property p_one_evt; tmr_one_counter_mode_i[*3] |-> !tmr_one_tick_o; endproperty
   a_one_evt: assert property (p_one_evt) else $error("timer one ticks as counter");
   property p_b_low; cks[4][*3] |-> tmr_b_low_tick_o; endproperty
   a_b_low: assert property (p_b_low) else $error("timer b low not on system_clock");
   property p_irq;
      tmr_c_irq_o == $past(ext_irq_enable_i && (ctl[7] || (ctl[5] && ctl[6])));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt request wrong");
   property p_ovf16;
      $rose(ctl[7]) && !ctl[3] && !$past(ctl_wr_i) |->
         cnt == 16'hffff;
   endproperty
   a_ovf16: assert property (p_ovf16) else $error("high flag without wrap");
   property p_ovf_low;
      $rose(ctl[6]) && !$past(ctl_wr_i) |->
         tmr_c_count_low_o == 8'hff;
   endproperty
   a_ovf_low: assert property (p_ovf_low) else $error("low flag without wrap");
   property p_tmo;
      (bus_low_timeout_en_i && bus_clk_line_i && quiet)[*6] |->
         cnt == {tmr_c_reload_high_o, tmr_c_reload_low_o};
   endproperty
   a_tmo: assert property (p_tmo) else $error("count not held at reload");
endmodule // tcs_timer_asserts

bind tcs_timer tcs_timer_asserts tcs_timer_asserts_inst (.clk_i(clk_i), .rst_i(rst_i),
   .cks_wr_i(cks_wr_i), .ctl_wr_i(ctl_wr_i), .cnt_low_wr_i(cnt_low_wr_i),
   .cnt_high_wr_i(cnt_high_wr_i), .rld_low_wr_i(rld_low_wr_i), .rld_high_wr_i(rld_high_wr_i),
   .ext_irq_enable_i(ext_irq_enable_i), .bus_low_timeout_en_i(bus_low_timeout_en_i),
   .tmr_zero_counter_mode_i(tmr_zero_counter_mode_i), .bus_clk_line_i(bus_clk_line_i),
   .tmr_one_counter_mode_i(tmr_one_counter_mode_i), .wdata_i(wdata_i),
   .timer_clock_select_o(timer_clock_select_o), .tmr_c_control_o(tmr_c_control_o),
   .tmr_c_count_low_o(tmr_c_count_low_o), .tmr_c_count_high_o(tmr_c_count_high_o),
   .tmr_c_reload_low_o(tmr_c_reload_low_o), .tmr_c_reload_high_o(tmr_c_reload_high_o),
   .tmr_zero_tick_o(tmr_zero_tick_o), .tmr_one_tick_o(tmr_one_tick_o),
   .tmr_b_low_tick_o(tmr_b_low_tick_o), .tmr_c_irq_o(tmr_c_irq_o));

// ### verif/tcs_timer_test.sv
// Self-checking bench for the timer clock select block
`timescale 1ns/1ps
module tcs_timer_test;
   reg        clk_i = 1'b0, rst_i = 1'b1, osc = 1'b0, en_irq = 1'b0;
   reg        m0 = 1'b0, m1 = 1'b0, tmo_en = 1'b0, scl = 1'b1;
   reg  [5:0] wr = 6'h00;
   reg  [7:0] wd = 8'h00;
   wire [7:0] cks, ctl, cl, ch, rl, rh;
   wire       t0, t1, tbl, tbh, irq;
   wire [3:0] tk = {tbh, tbl, t1, t0};
   int        n_mismatch = 0;
   int        num_checks = 0;
   localparam CKS = 0, CTL = 1, CNL = 2, CNH = 3, RLL = 4, RLH = 5;
   // Clock and an unrelated slow external oscillator
   always #25 clk_i = ~clk_i;
   always #85 osc = ~osc;
   tcs_timer tcs_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .cks_wr_i(wr[0]), .ctl_wr_i(wr[1]),
      .cnt_low_wr_i(wr[2]), .cnt_high_wr_i(wr[3]), .rld_low_wr_i(wr[4]),
      .rld_high_wr_i(wr[5]), .wdata_i(wd), .ext_irq_enable_i(en_irq),
      .tmr_zero_counter_mode_i(m0), .tmr_one_counter_mode_i(m1),
      .tmr_b_ext_clk_choice_i(1'b0), .tmr_b_split_mode_i(1'b0), .ext_osc_i(osc),
      .bus_low_timeout_en_i(tmo_en), .bus_clk_line_i(scl), .timer_clock_select_o(cks),
      .tmr_c_control_o(ctl), .tmr_c_count_low_o(cl), .tmr_c_count_high_o(ch),
      .tmr_c_reload_low_o(rl), .tmr_c_reload_high_o(rh), .tmr_zero_tick_o(t0),
      .tmr_one_tick_o(t1), .tmr_b_low_tick_o(tbl), .tmr_b_high_tick_o(tbh), .tmr_c_irq_o(irq));
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input [15:0] e, input [15:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Sample a little after the edge so its updates have landed
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic put(input int k, input [7:0] d);
      @(posedge clk_i);
      wr[k] <= 1'b1;
      wd <= d;
      @(posedge clk_i);
      wr <= 6'h00;
   endtask
   task automatic wait_bit(input int b);
      int i;
      for (i = 0; i < 2000 && ctl[b] !== 1'b1; i++) cyc(1);
      if (i == 2000) begin
         n_mismatch++;
         $display("Error control bit %0d never set", b);
         conclude();
      end
   endtask
   // Gap between two ticks; a missing tick gives a wrong gap, not a hang
   task automatic period(input int k, input [15:0] e);
      int i, a;
      a = -1;
      for (i = 0; i < 300; i++) begin
         cyc(1);
         if (tk[k] === 1'b1) begin
            if (a >= 0) break;
            a = i;
         end
      end
      chk("tick_period", e, 16'(i - a));
   endtask
   task automatic t_regs;
      chk("cks_reset", 16'h0000, 16'(cks));
      chk("ctl_reset", 16'h0000, 16'(ctl));
      put(CKS, 8'ha5);
      cyc(2);
      chk("cks_rw", 16'h00a5, 16'(cks));
      $display("test regs done");
   endtask
   task automatic t_presc;
      int c;
      int e;
      for (c = 0; c < 4; c++) begin
         e = (c == 1) ? 4 : (c == 2) ? 48 : 12;
         put(CKS, 8'(c));
         cyc(100);
         period(0, 16'(e));
         period(1, 16'(e));
      end
      period(2, 16'd12);
      $display("test prescale done");
   endtask
   task automatic t_sel;
      put(CKS, 8'h1c);
      cyc(4);
      chk("sys_ticks", 16'h000f, 16'(tk));
      @(posedge clk_i);
      m0 <= 1'b1;
      m1 <= 1'b1;
      cyc(4);
      chk("event_ticks", 16'h000c, 16'(tk));
      @(posedge clk_i);
      m0 <= 1'b0;
      m1 <= 1'b0;
      $display("test select done");
   endtask
   // Sys/12 count keeps the reload value visible for twelve cycles
   task automatic t_c16;
      @(posedge clk_i);
      en_irq <= 1'b1;
      put(RLL, 8'h34);
      put(RLH, 8'h12);
      put(CNL, 8'hff);
      put(CNH, 8'hff);
      put(CTL, 8'h04);
      wait_bit(7);
      cyc(1);
      chk("reload16", 16'h1234, {ch, cl});
      chk("ovf_irq", 16'h0001, 16'(irq));
      put(CTL, 8'h04);
      cyc(2);
      chk("irq_cleared", 16'h0000, 16'(irq));
      put(CTL, 8'h24);
      put(CNL, 8'hff);
      wait_bit(6);
      cyc(1);
      chk("low_irq", 16'h0001, 16'(irq));
      chk("no_high_ovf", 16'h0000, 16'(ctl[7]));
      put(CTL, 8'h04);
      put(CNL, 8'hff);
      wait_bit(6);
      cyc(1);
      chk("low_irq_off", 16'h0000, 16'(irq));
      $display("test timer c done");
   endtask
   task automatic t_tmo;
      @(posedge clk_i);
      tmo_en <= 1'b1;
      cyc(10);
      chk("held_reload", 16'h1234, {ch, cl});
      @(posedge clk_i);
      scl <= 1'b0;
      cyc(40);
      chk("counts_low", 16'h0001, 16'({ch, cl} != 16'h1234));
      // Handler-style bus reset: disable, release the line, enable again
      @(posedge clk_i);
      tmo_en <= 1'b0;
      scl <= 1'b1;
      @(posedge clk_i);
      tmo_en <= 1'b1;
      cyc(10);
      chk("rearm_reload", 16'h1234, {ch, cl});
      $display("test timeout done");
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      cyc(1);
      t_regs();
      t_presc();
      t_sel();
      t_c16();
      t_tmo();
      conclude();
   end
endmodule // tcs_timer_test
